// ==== inc/trc_cfg.svh ====
// Constants of the tiny RISC core datapath
`ifndef TRC_CFG_SVH
`define TRC_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TRC_PC_W          9
`define TRC_INSN_W        12
`define TRC_DATA_W        8
`define TRC_FADDR_W       5
`define TRC_RADDR_W       4

// ----------------------------------------
// Timing
// ----------------------------------------
`define TRC_REF_CLK_NS    40
`define TRC_OSC_PER_INSN  4
`define TRC_LAST_PHASE    2'h3

// ----------------------------------------
// Core reset values and encodings
// ----------------------------------------
`define TRC_PC_RESET      9'h1FF
`define TRC_NOP           12'h000

// ----------------------------------------
// Data space map
// ----------------------------------------
`define TRC_ADDR_INDF     5'h00
`define TRC_ADDR_PCL      5'h02
`define TRC_ADDR_STATUS   5'h03
`define TRC_ADDR_FSR      5'h04
`define TRC_ST_Z          2
`define TRC_ST_DC         1
`define TRC_ST_C          0

// ----------------------------------------
// Control port registers
// ----------------------------------------
`define TRC_REG_CTRL      4'h0
`define TRC_REG_W         4'h1
`define TRC_REG_STATUS    4'h2
`define TRC_REG_PC_LO     4'h3
`define TRC_REG_PC_HI     4'h4
`define TRC_REG_IR_LO     4'h5
`define TRC_REG_IR_HI     4'h6
`define TRC_REG_FSR       4'h7
`define TRC_CTRL_RESET    2'h3
`define TRC_CTRL_RUN      0
`define TRC_CTRL_MASTER_CLEAR_PIN_EN  1

`endif

// ==== inc/trc_pkg.sv ====
// Types shared by the tiny RISC core files
`include "trc_cfg.svh"
package trc_pkg;
  typedef enum logic [3:0] {
    ALU_PASS_A, ALU_PASS_W, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
    ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_BCLR, ALU_BSET
  } trc_alu_op_e;

  typedef struct packed {
    logic                       we;
    logic [`TRC_FADDR_W-1:0]    addr;
    logic [`TRC_DATA_W-1:0]     wdata;
  } trc_dmem_req_s;
endpackage

// ==== rtl/trc_phase_div.sv ====
// Instruction cycle phase divider
`timescale 1ns/100ps
`default_nettype none
`include "trc_cfg.svh"
module trc_phase_div (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_clr,
  input  wire logic        i_en,
  output logic [1:0]       o_phase,
  output logic             o_cycle_end
);
  import trc_pkg::*;
  logic [1:0] phase_reg;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_reg <= 2'h0;
    end else if (i_clr) begin
      phase_reg <= 2'h0;
    end else if (i_en) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign o_phase     = phase_reg;
  assign o_cycle_end = i_en & ~i_clr & (phase_reg == `TRC_LAST_PHASE);
endmodule
`default_nettype wire

// ==== rtl/trc_alu.sv ====
// Eight-bit arithmetic and logic unit
`timescale 1ns/100ps
`default_nettype none
`include "trc_cfg.svh"
module trc_alu (
  input  wire logic [`TRC_DATA_W-1:0]  i_a,
  input  wire logic [`TRC_DATA_W-1:0]  i_w,
  input  wire trc_pkg::trc_alu_op_e    i_op,
  input  wire logic [2:0]              i_bit,
  input  wire logic                    i_carry,
  output logic [`TRC_DATA_W-1:0]       o_res,
  output logic                         o_c,
  output logic                         o_dc,
  output logic                         o_z
);
  import trc_pkg::*;
  // Subtract is f + ~w + 1, so carry out already means no borrow
  wire       is_sub = (i_op == ALU_SUB);
  wire [7:0] b_opnd = is_sub ? ~i_w : i_w;
  wire [8:0] sum    = {1'b0, i_a} + {1'b0, b_opnd} + {8'h00, is_sub};
  wire [4:0] nib    = {1'b0, i_a[3:0]} + {1'b0, b_opnd[3:0]} + {4'h0, is_sub};
  wire [7:0] mask   = 8'h01 << i_bit;

  always_comb begin
    o_c = sum[8];
    case (i_op)
      ALU_PASS_A: o_res = i_a;
      ALU_PASS_W: o_res = i_w;
      ALU_CLR:    o_res = 8'h00;
      ALU_ADD:    o_res = sum[7:0];
      ALU_SUB:    o_res = sum[7:0];
      ALU_AND:    o_res = i_a & i_w;
      ALU_IOR:    o_res = i_a | i_w;
      ALU_XOR:    o_res = i_a ^ i_w;
      ALU_COM:    o_res = ~i_a;
      ALU_INC:    o_res = i_a + 8'h01;
      ALU_DEC:    o_res = i_a - 8'h01;
      ALU_RR: begin
        o_res = {i_carry, i_a[7:1]};
        o_c   = i_a[0];
      end
      ALU_RL: begin
        o_res = {i_a[6:0], i_carry};
        o_c   = i_a[7];
      end
      ALU_SWAP:   o_res = {i_a[3:0], i_a[7:4]};
      ALU_BCLR:   o_res = i_a & ~mask;
      default:    o_res = i_a | mask;
    endcase
  end

  assign o_dc = nib[4];
  assign o_z  = (o_res == 8'h00);
endmodule
`default_nettype wire

// ==== rtl/trc_core.sv ====
// Tiny RISC core: fetch/execute pipeline, datapath and control port
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "trc_cfg.svh"
module trc_core (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_master_clear_pin_n,
  output logic [`TRC_PC_W-1:0]         o_pmem_addr,
  input  wire logic [`TRC_INSN_W-1:0]  i_pmem_data,
  output trc_pkg::trc_dmem_req_s       o_dmem,
  input  wire logic [`TRC_DATA_W-1:0]  i_dmem_rdata,
  output logic                         o_quarter_osc_output,
  output logic                         o_in_reset,
  input  wire logic [`TRC_RADDR_W-1:0] i_reg_addr,
  input  wire logic [`TRC_DATA_W-1:0]  i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic [`TRC_DATA_W-1:0]       o_reg_rdata
);
  import trc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`TRC_PC_W-1:0]    pc_reg;
  logic [`TRC_PC_W-1:0]    pc_next;
  logic [`TRC_INSN_W-1:0]  ir_reg;
  logic [`TRC_DATA_W-1:0]  w_reg;
  logic [`TRC_DATA_W-1:0]  fsr_reg;
  logic [2:0]              status_reg;
  logic [2:0]              status_next;
  logic [`TRC_DATA_W-1:0]  opnd_reg;
  logic [`TRC_PC_W-1:0]    stk1_reg;
  logic [`TRC_PC_W-1:0]    stk2_reg;
  logic [1:0]              ctrl_reg;
  trc_dmem_req_s           dmem_reg;
  logic [`TRC_DATA_W-1:0]  rdata_reg;
  logic [1:0]              phase;
  logic                    cycle_end;

  // ----------------------------------------
  // Reset and timing
  // ----------------------------------------
  wire core_hold = ctrl_reg[`TRC_CTRL_MASTER_CLEAR_PIN_EN] & ~i_master_clear_pin_n;
  wire run       = ctrl_reg[`TRC_CTRL_RUN];

  trc_phase_div u_div (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_clr       (core_hold),
    .i_en        (run),
    .o_phase     (phase),
    .o_cycle_end (cycle_end)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  trc_alu_op_e alu_op;
  logic        wr_w;
  logic        wr_f;
  logic        fl_z;
  logic        fl_arith;
  logic        fl_rot;
  logic        skip_zero;
  logic        tst_clr;
  logic        tst_set;
  logic        is_ret;
  logic        is_call;
  logic        is_goto;
  logic        use_lit;

  wire       dest_f = ir_reg[5];
  wire [2:0] bit_no = ir_reg[7:5];
  wire [7:0] lit    = ir_reg[7:0];
  // Indirect slot redirects through the pointer, any op on any register
  wire [4:0] fa = (ir_reg[4:0] == `TRC_ADDR_INDF) ? fsr_reg[4:0] : ir_reg[4:0];

  always_comb begin
    alu_op    = ALU_PASS_A;
    wr_w      = 1'b0;
    wr_f      = 1'b0;
    fl_z      = 1'b0;
    fl_arith  = 1'b0;
    fl_rot    = 1'b0;
    skip_zero = 1'b0;
    tst_clr   = 1'b0;
    tst_set   = 1'b0;
    is_ret    = 1'b0;
    is_call   = 1'b0;
    is_goto   = 1'b0;
    use_lit   = ir_reg[11];
    casez (ir_reg[11:6])
      6'b000000: begin
        alu_op = ALU_PASS_W;
        wr_f   = dest_f;
      end
      6'b000001: begin alu_op = ALU_CLR;  fl_z = 1'b1; end
      6'b000010: begin alu_op = ALU_SUB;  fl_arith = 1'b1; end
      6'b000011: begin alu_op = ALU_DEC;  fl_z = 1'b1; end
      6'b000100: begin alu_op = ALU_IOR;  fl_z = 1'b1; end
      6'b000101: begin alu_op = ALU_AND;  fl_z = 1'b1; end
      6'b000110: begin alu_op = ALU_XOR;  fl_z = 1'b1; end
      6'b000111: begin alu_op = ALU_ADD;  fl_arith = 1'b1; end
      6'b001000: begin alu_op = ALU_PASS_A; fl_z = 1'b1; end
      6'b001001: begin alu_op = ALU_COM;  fl_z = 1'b1; end
      6'b001010: begin alu_op = ALU_INC;  fl_z = 1'b1; end
      6'b001011: begin alu_op = ALU_DEC;  skip_zero = 1'b1; end
      6'b001100: begin alu_op = ALU_RR;   fl_rot = 1'b1; end
      6'b001101: begin alu_op = ALU_RL;   fl_rot = 1'b1; end
      6'b001110: alu_op = ALU_SWAP;
      6'b001111: begin alu_op = ALU_INC;  skip_zero = 1'b1; end
      6'b0100??: begin alu_op = ALU_BCLR; wr_f = 1'b1; end
      6'b0101??: begin alu_op = ALU_BSET; wr_f = 1'b1; end
      6'b0110??: tst_clr = 1'b1;
      6'b0111??: tst_set = 1'b1;
      6'b1000??: begin is_ret = 1'b1; wr_w = 1'b1; end
      6'b1001??: is_call = 1'b1;
      6'b101???: is_goto = 1'b1;
      6'b1100??: wr_w = 1'b1;
      6'b1101??: begin alu_op = ALU_IOR; wr_w = 1'b1; fl_z = 1'b1; end
      6'b1110??: begin alu_op = ALU_AND; wr_w = 1'b1; fl_z = 1'b1; end
      default:   begin alu_op = ALU_XOR; wr_w = 1'b1; fl_z = 1'b1; end
    endcase
    if (ir_reg[11:10] == 2'b00 && ir_reg[11:6] != 6'b000000) begin
      wr_w = ~dest_f;
      wr_f = dest_f;
    end
  end

  // ----------------------------------------
  // Operand fetch and ALU
  // ----------------------------------------
  // Special registers live here so ordinary data ops reach them
  wire sfr_hit = (fa == `TRC_ADDR_INDF) | (fa == `TRC_ADDR_PCL) |
                 (fa == `TRC_ADDR_STATUS) | (fa == `TRC_ADDR_FSR);
  wire [7:0] sfr_rd = (fa == `TRC_ADDR_PCL)    ? pc_reg[7:0] :
                      (fa == `TRC_ADDR_STATUS) ? {5'h00, status_reg} :
                      (fa == `TRC_ADDR_FSR)    ? fsr_reg : 8'h00;
  wire [7:0] file_rd = sfr_hit ? sfr_rd : i_dmem_rdata;

  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;

  trc_alu u_alu (
    .i_a     (use_lit ? lit : opnd_reg),
    .i_w     (w_reg),
    .i_op    (alu_op),
    .i_bit   (bit_no),
    .i_carry (status_reg[`TRC_ST_C]),
    .o_res   (alu_res),
    .o_c     (alu_c),
    .o_dc    (alu_dc),
    .o_z     (alu_z)
  );

  // ----------------------------------------
  // Branch and flag resolution
  // ----------------------------------------
  wire pcl_wr   = wr_f & (fa == `TRC_ADDR_PCL);
  wire st_wr    = wr_f & (fa == `TRC_ADDR_STATUS);
  wire fsr_wr   = wr_f & (fa == `TRC_ADDR_FSR);
  wire ext_wr   = wr_f & ~sfr_hit;
  wire tst_bit  = opnd_reg[bit_no];
  wire do_skip  = (skip_zero & alu_z) | (tst_clr & ~tst_bit) | (tst_set & tst_bit);
  wire branch   = is_goto | is_call | is_ret | pcl_wr | do_skip;
  wire commit   = cycle_end & ~core_hold;

  always_comb begin
    pc_next = pc_reg + 9'h001;
    if (is_goto) begin
      pc_next = ir_reg[8:0];
    end else if (is_call) begin
      pc_next = {1'b0, lit};
    end else if (is_ret) begin
      pc_next = stk1_reg;
    end else if (pcl_wr) begin
      pc_next = {1'b0, alu_res};
    end
  end

  always_comb begin
    status_next = st_wr ? alu_res[2:0] : status_reg;
    if (fl_z | fl_arith) begin
      status_next[`TRC_ST_Z] = alu_z;
    end
    if (fl_arith) begin
      status_next[`TRC_ST_DC] = alu_dc;
    end
    if (fl_arith | fl_rot) begin
      status_next[`TRC_ST_C] = alu_c;
    end
  end

  // ----------------------------------------
  // Pipeline: fetch overlaps execute
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_reg <= `TRC_PC_RESET;
      ir_reg <= `TRC_NOP;
    end else if (core_hold) begin
      pc_reg <= `TRC_PC_RESET;
      ir_reg <= `TRC_NOP;
    end else if (cycle_end) begin
      pc_reg <= pc_next;
      ir_reg <= branch ? `TRC_NOP : i_pmem_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_reg      <= 8'h00;
      fsr_reg    <= 8'h00;
      status_reg <= 3'h0;
      stk1_reg   <= 9'h000;
      stk2_reg   <= 9'h000;
    end else if (commit) begin
      w_reg      <= wr_w ? alu_res : w_reg;
      fsr_reg    <= fsr_wr ? alu_res : fsr_reg;
      status_reg <= status_next;
      stk1_reg   <= is_call ? pc_reg : (is_ret ? stk2_reg : stk1_reg);
      stk2_reg   <= is_call ? stk1_reg : stk2_reg;
    end
  end

  // ----------------------------------------
  // Data bus: address in phase 1, write in phase 3
  // ----------------------------------------
  // Data bus runs on its own port, free of the fetch port
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dmem_reg <= '0;
      opnd_reg <= 8'h00;
    end else if (core_hold) begin
      dmem_reg.we <= 1'b0;
    end else if (run) begin
      if (phase == 2'h0) begin
        dmem_reg.addr <= fa;
      end
      if (phase == 2'h1) begin
        opnd_reg <= file_rd;
      end
      dmem_reg.we <= (phase == 2'h2) & ext_wr;
      if (phase == 2'h2) begin
        dmem_reg.wdata <= alu_res;
      end
    end
  end

  // ----------------------------------------
  // Control port
  // ----------------------------------------
  wire [7:0] reg_rd_mux =
    (i_reg_addr == `TRC_REG_CTRL)   ? {6'h00, ctrl_reg} :
    (i_reg_addr == `TRC_REG_W)      ? w_reg :
    (i_reg_addr == `TRC_REG_STATUS) ? {5'h00, status_reg} :
    (i_reg_addr == `TRC_REG_PC_LO)  ? pc_reg[7:0] :
    (i_reg_addr == `TRC_REG_PC_HI)  ? {7'h00, pc_reg[8]} :
    (i_reg_addr == `TRC_REG_IR_LO)  ? ir_reg[7:0] :
    (i_reg_addr == `TRC_REG_IR_HI)  ? {4'h0, ir_reg[11:8]} :
    (i_reg_addr == `TRC_REG_FSR)    ? fsr_reg : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg  <= `TRC_CTRL_RESET;
      rdata_reg <= 8'h00;
    end else begin
      if (i_reg_wr && i_reg_addr == `TRC_REG_CTRL) begin
        ctrl_reg <= i_reg_wdata[1:0];
      end
      rdata_reg <= i_reg_rd ? reg_rd_mux : 8'h00;
    end
  end

  assign o_pmem_addr          = pc_reg;
  assign o_dmem               = dmem_reg;
  assign o_quarter_osc_output = phase[1];
  assign o_in_reset           = core_hold;
  assign o_reg_rdata          = rdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  wire       sub_nb  = (opnd_reg >= w_reg);
  wire [4:0] fsr_lo  = fsr_reg[4:0];
  wire       ind_sel = (ir_reg[4:0] == `TRC_ADDR_INDF);

  chk_cycle_four: assert property (cycle_end |=> !cycle_end [*3])
    else $error("instruction cycle shorter than four clocks");
  chk_branch_flush: assert property (commit && branch |=> ir_reg == `TRC_NOP)
    else $error("fetched word not discarded after branch");
  chk_fetch_load: assert property (commit && !branch |=> ir_reg == $past(i_pmem_data))
    else $error("fetched word not loaded whole");
  chk_pc_step: assert property (commit && !branch && !pcl_wr |=> pc_reg == $past(pc_reg) + 9'h001)
    else $error("pointer did not step during overlapped fetch");
  chk_zero_flag: assert property (commit && fl_z |=> status_reg[`TRC_ST_Z] == $past(alu_z))
    else $error("zero flag wrong");
  chk_sub_borrow: assert property (commit && alu_op == ALU_SUB |=> status_reg[`TRC_ST_C] == $past(sub_nb))
    else $error("carry not no-borrow on subtract");
  chk_master_clear_pin_hold: assert property (core_hold |=> pc_reg == `TRC_PC_RESET && ir_reg == `TRC_NOP && !o_dmem.we)
    else $error("master clear did not hold core");
  chk_indirect_addr: assert property (run && !core_hold && phase == 2'h0 && ind_sel
                                      |=> o_dmem.addr == $past(fsr_lo))
    else $error("indirect access missed pointer");
  chk_rd_once: assert property (i_reg_rd ##1 !i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data stood past its cycle");

  cov_branch: cover property (commit && is_goto);
  cov_skip: cover property (commit && do_skip);
  cov_sub: cover property (commit && alu_op == ALU_SUB && !sub_nb);
  cov_ind_wr: cover property (o_dmem.we && ind_sel);
endmodule
`default_nettype wire

// ==== tb/trc_mem_model.sv ====
// Program and data memory arrays beside the core
`timescale 1ns/100ps
`default_nettype none
`include "trc_cfg.svh"
module trc_mem_model (
  input  wire logic                    i_ref_clk,
  input  wire logic [`TRC_PC_W-1:0]    i_pmem_addr,
  output logic [`TRC_INSN_W-1:0]       o_pmem_data,
  input  wire trc_pkg::trc_dmem_req_s  i_dmem,
  output logic [`TRC_DATA_W-1:0]       o_dmem_rdata,
  output logic                         o_bad_wr
);
  import trc_pkg::*;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [`TRC_INSN_W-1:0] prog_mem [0:511];
  logic [`TRC_DATA_W-1:0] data_mem [0:31];
  logic                   internal_sel;
  initial begin
    o_bad_wr = 1'b0;
    for (int i = 0; i < 512; i++) begin
      prog_mem[i] = `TRC_NOP;
    end
    for (int i = 0; i < 32; i++) begin
      data_mem[i] = 8'h00;
    end
  end
  // ----------------------------------------
  // Buses
  // ----------------------------------------
  // Whole word on its own bus, no wait
  assign o_pmem_data  = prog_mem[i_pmem_addr];
  // Core owns these; garbage here must never reach it
  assign internal_sel = (i_dmem.addr == 5'h00) || (i_dmem.addr >= 5'h02 && i_dmem.addr <= 5'h04);
  assign o_dmem_rdata = internal_sel ? 8'h5A : data_mem[i_dmem.addr];
  always @(posedge i_ref_clk) begin
    if (i_dmem.we === 1'b1) begin
      data_mem[i_dmem.addr] <= i_dmem.wdata;
      if (internal_sel) begin
        o_bad_wr <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_tiny_risc_core_datapath.sv ====
// Self-checking bench of the tiny RISC core
`timescale 1ns/100ps
`default_nettype none
`include "trc_cfg.svh"
module tb_tiny_risc_core_datapath;
  import trc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                    i_ref_clk = 1'b0;
  logic                    i_rstn;
  logic                    i_master_clear_pin_n;
  logic [`TRC_PC_W-1:0]    o_pmem_addr;
  logic [`TRC_INSN_W-1:0]  pmem_data;
  trc_dmem_req_s           o_dmem;
  logic [`TRC_DATA_W-1:0]  dmem_rdata;
  logic                    o_quarter_osc_output;
  logic                    o_in_reset;
  logic [`TRC_RADDR_W-1:0] i_reg_addr;
  logic [`TRC_DATA_W-1:0]  i_reg_wdata;
  logic                    i_reg_wr;
  logic                    i_reg_rd;
  logic [`TRC_DATA_W-1:0]  o_reg_rdata;
  logic                    bad_wr;
  int                      num_errors;
  int                      checked;
  int                      cycles = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  trc_core trc_core_inst (
    .i_ref_clk            (i_ref_clk),
    .i_rstn               (i_rstn),
    .i_master_clear_pin_n (i_master_clear_pin_n),
    .o_pmem_addr          (o_pmem_addr),
    .i_pmem_data          (pmem_data),
    .o_dmem               (o_dmem),
    .i_dmem_rdata         (dmem_rdata),
    .o_quarter_osc_output (o_quarter_osc_output),
    .o_in_reset           (o_in_reset),
    .i_reg_addr           (i_reg_addr),
    .i_reg_wdata          (i_reg_wdata),
    .i_reg_wr             (i_reg_wr),
    .i_reg_rd             (i_reg_rd),
    .o_reg_rdata          (o_reg_rdata)
  );
  trc_mem_model trc_mem_model_inst (
    .i_ref_clk    (i_ref_clk),
    .i_pmem_addr  (o_pmem_addr),
    .o_pmem_data  (pmem_data),
    .i_dmem       (o_dmem),
    .o_dmem_rdata (dmem_rdata),
    .o_bad_wr     (bad_wr)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Well above the few hundred cycles the tests need
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd   <= 1'b0;
    @(negedge i_ref_clk);
    d = o_reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
  endtask
  // Freeze at phase 0 of the cycle where the pointer turns to a
  task automatic stop_at(input logic [8:0] a);
    @(negedge i_ref_clk);
    while (!(o_pmem_addr === a - 9'h001 && o_quarter_osc_output === 1'b1)) @(negedge i_ref_clk);
    wr(`TRC_REG_CTRL, 8'h02);
  endtask
  task automatic span(input logic [8:0] from, input logic [8:0] to, output int n, output int hi);
    n  = 0;
    hi = 0;
    while (o_pmem_addr !== from) @(negedge i_ref_clk);
    while (o_pmem_addr !== to) begin
      n++;
      if (o_quarter_osc_output === 1'b1) hi++;
      @(negedge i_ref_clk);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_timing();
    int n;
    int hi;
    span(9'h001, 9'h002, n, hi);
    check(12'(n), 12'h004);
    check(12'(hi), 12'h002);
    span(9'h00C, 9'h011, n, hi);
    check(12'(n), 12'h008);
  endtask
  task automatic check_stop(input logic [8:0] a, input logic [7:0] w, input logic [7:0] st);
    logic [7:0] d;
    stop_at(a);
    rd(`TRC_REG_W, d);
    check({4'h0, d}, {4'h0, w});
    rd(`TRC_REG_STATUS, d);
    check({4'h0, d}, {4'h0, st});
    wr(`TRC_REG_CTRL, `TRC_CTRL_RESET);
  endtask
  task automatic test_datapath();
    logic [7:0] d;
    check_stop(9'h004, 8'h00, 8'h07);
    check_stop(9'h005, 8'h0F, 8'h03);
    check_stop(9'h007, 8'hF1, 8'h02);
    check_stop(9'h008, 8'h0E, 8'h02);
    check_stop(9'h00C, 8'h0B, 8'h02);
    // Word after the jump must not load W
    check_stop(9'h011, 8'h0B, 8'h02);
    rd(`TRC_REG_FSR, d);
    check({4'h0, d}, 12'h011);
    check({4'h0, trc_mem_model_inst.data_mem[16]}, 12'h00F);
    check({4'h0, trc_mem_model_inst.data_mem[17]}, 12'h011);
    check({11'h000, bad_wr}, 12'h000);
  endtask
  task automatic test_master_clear();
    logic [7:0] d;
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check({11'h000, o_in_reset}, 12'h001);
    check({3'h0, o_pmem_addr}, 12'h1FF);
    rd(`TRC_REG_W, d);
    check({4'h0, d}, 12'h00B);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b1;
    check_stop(9'h001, 8'h0F, 8'h02);
    // Pin as plain input: low level must not reset
    wr(`TRC_REG_CTRL, 8'h01);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check({11'h000, o_in_reset}, 12'h000);
    check({11'h000, o_pmem_addr === 9'h1FF}, 12'h000);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b1;
    wr(`TRC_REG_CTRL, `TRC_CTRL_RESET);
  endtask
  task automatic test_ctrl_port();
    logic [7:0] d;
    rd(`TRC_REG_CTRL, d);
    check({4'h0, d}, 12'h003);
    wr(`TRC_REG_W, 8'h55);
    stop_at(9'h004);
    rd(`TRC_REG_W, d);
    check({4'h0, d}, 12'h000);
    rd(4'h8, d);
    check({4'h0, d}, 12'h000);
    wr(`TRC_REG_CTRL, `TRC_CTRL_RESET);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rstn               = 1'b0;
    i_master_clear_pin_n = 1'b1;
    i_reg_addr           = 4'h0;
    i_reg_wdata          = 8'h00;
    i_reg_wr             = 1'b0;
    i_reg_rd             = 1'b0;
    num_errors           = 0;
    checked              = 0;
    trc_mem_model_inst.prog_mem[511] = 12'hC0F;
    trc_mem_model_inst.prog_mem[0]   = 12'h030;
    trc_mem_model_inst.prog_mem[1]   = 12'hCF1;
    trc_mem_model_inst.prog_mem[2]   = 12'h1D0;
    trc_mem_model_inst.prog_mem[3]   = 12'h090;
    trc_mem_model_inst.prog_mem[4]   = 12'hC1E;
    trc_mem_model_inst.prog_mem[5]   = 12'h090;
    trc_mem_model_inst.prog_mem[6]   = 12'hFFF;
    trc_mem_model_inst.prog_mem[7]   = 12'hC11;
    trc_mem_model_inst.prog_mem[8]   = 12'h024;
    trc_mem_model_inst.prog_mem[9]   = 12'h020;
    trc_mem_model_inst.prog_mem[10]  = 12'h202;
    trc_mem_model_inst.prog_mem[11]  = 12'hA10;
    trc_mem_model_inst.prog_mem[12]  = 12'hCAA;
    trc_mem_model_inst.prog_mem[16]  = 12'hA10;
    do_reset();
    test_timing();
    do_reset();
    test_datapath();
    test_master_clear();
    do_reset();
    test_ctrl_port();
    summarize();
  end
endmodule
`default_nettype wire
